// [logic/smi2c_slave.sv]
// serial module two-wire slave with mode/enable/clock-output control and wishbone registers
//
// Function
// RULE_01: data and clock lines only pulled low or released, never driven high.
// RULE_02: no select input; device addressed only by bus address.
// RULE_03: device is only a slave, transmitting or receiving.
// RULE_04: external master makes start, stop and the serial clock.
// RULE_05: without the pin option the enable bit does nothing; pins stay I/O.
// RULE_06: build option: clock glitch filter off, 2 or 4 system clocks.
// RULE_07: mode 110 two-wire slave, 101 SPI slave, 111 unused, rest SPI master.
// RULE_08: SPI master shift clock from mode: /4, /16, /64, time-base, timer half-rate.
// RULE_09: SPI slave mode takes its shift clock from the external master.
// RULE_10: control bit 4 gates the clock-output pin.
// RULE_11: clock-output select: system, /4, /8, timer match half-rate.
// RULE_12: enable low releases all module pins and halts module activity; with control bit 4 set the clock-output pin and prescaler keep running.
// RULE_13: enable high activates the interface in the selected mode.
// RULE_14: enable rising keeps SPI control settings unchanged.
// RULE_15: enable rising keeps direction-select and ack-to-send bits.
// RULE_16: enable rising resets complete, match, busy, read/write, received-ack flags.
// RULE_17: control register bit 0 unimplemented, reads zero.
// RULE_18: shared data register carries every bus byte. The address byte is never loaded into it here.
// RULE_19: software loads the transmit byte before it is sent.
// RULE_20: received byte readable from the shared data register.
// RULE_21: complete flag low during a byte, high and interrupt at its end.
// RULE_22: address-match flag follows comparison of bus address with slave address.
// RULE_23: busy flag set on start, cleared on stop.
// RULE_24: ack-to-send bit driven on data line in the ninth clock.
// RULE_25: filtered clock changes only after the selected stable run.
// RULE_26: slave idle unless enabled and in two-wire slave mode.
`timescale 1ns/1ps
module smi2c_slave
  import smi2c_pkg::*;
#(
  parameter bit PIN_OPTION = 1'b1,
  parameter logic [2:0] DEBOUNCE_CYCLES = DEBOUNCE_OFF
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // two-wire bus pins, open drain
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_O,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  // clock sources and clock-output pin
  input wire logic TBC_TICK_I,
  input wire logic TM0_MATCH_I,
  output logic CLOCK_OUT_PIN_O,
  // status to the rest of the chip
  output logic IRQ_PULSE_O,
  output logic SPI_SHIFT_TICK_O,
  output logic SPI_EXT_CLOCK_O
);
  logic [7:0] mode_enable_control;
  logic [7:0] shared_data;
  logic [7:0] slave_address;
  logic direction_select;
  logic ack_to_send;
  logic address_wake_enable;
  logic transfer_complete_flag;
  logic address_match_flag;
  logic bus_busy_flag;
  logic read_write_flag;
  logic received_ack_flag;
  logic [2:0] mode_field;
  logic module_enable;
  logic enable_q;
  logic enable_rise;
  logic twowire_active;
  logic wb_req;
  logic wb_write;
  logic byte_wr;
  logic [7:0] twowire_status_control;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_filt;
  logic scl_prev;
  logic sda_prev;
  logic [2:0] deb_cnt;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  smi2c_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic sda_low;
  logic [PRESC_W-1:0] presc;
  logic tm0_half;
  logic clkout_div;
  logic [5:0] spi_last;

  assign mode_field = mode_enable_control[MODE_MSB:MODE_LSB];
  assign module_enable = mode_enable_control[MODULE_EN_BIT] & PIN_OPTION; // [RULE_05]
  assign twowire_active = module_enable && mode_field == MODE_TWOWIRE_SLAVE; // [RULE_07] [RULE_13]
  assign enable_rise = module_enable & ~enable_q;
  assign wb_req = CYC_I & STB_I & ~ACK_O;
  assign wb_write = wb_req & WE_I;
  assign byte_wr = wb_write & SEL_I[0];

  // single-cycle answer: ack one edge after request, dropped next cycle
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ACK_O <= 1'b0;
    end else begin
      ACK_O <= wb_req;
    end
  end

  assign twowire_status_control = {transfer_complete_flag, address_match_flag, bus_busy_flag,
    direction_select, ack_to_send, read_write_flag, address_wake_enable, received_ack_flag};

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      DAT_O <= 32'h0000_0000;
    end else if (wb_req && !WE_I) begin
      case (ADR_I)
        ADDR_MODE_ENABLE_CONTROL: DAT_O <= {24'h00_0000, mode_enable_control[7:1], 1'b0}; // [RULE_17]
        ADDR_TWOWIRE_STATUS_CONTROL: DAT_O <= {24'h00_0000, twowire_status_control};
        ADDR_SHARED_DATA: DAT_O <= {24'h00_0000, shared_data}; // [RULE_20]
        ADDR_SLAVE_ADDRESS: DAT_O <= {24'h00_0000, slave_address};
        default: DAT_O <= 32'h0000_0000;
      endcase
    end
  end

  // control register; enable bit has no effect without the pin option
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mode_enable_control <= MODE_ENABLE_RESET;
    end else if (byte_wr && ADR_I == ADDR_MODE_ENABLE_CONTROL) begin
      mode_enable_control <= {DAT_I[7:2], DAT_I[MODULE_EN_BIT] & PIN_OPTION, 1'b0}; // [RULE_05] [RULE_17]
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= module_enable;
    end
  end

  // shared with SPI as its second control register; untouched by enable edges
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      slave_address <= SLAVE_ADDRESS_RESET;
    end else if (byte_wr && ADR_I == ADDR_SLAVE_ADDRESS) begin
      slave_address <= DAT_I[7:0]; // [RULE_14]
    end
  end

  // software control bits keep their value across enable edges
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      direction_select <= STATUS_RESET[DIR_BIT];
      ack_to_send <= STATUS_RESET[ACK_BIT];
      address_wake_enable <= STATUS_RESET[WAKE_BIT];
    end else if (byte_wr && ADR_I == ADDR_TWOWIRE_STATUS_CONTROL) begin
      direction_select <= DAT_I[DIR_BIT]; // [RULE_15]
      ack_to_send <= DAT_I[ACK_BIT];
      address_wake_enable <= DAT_I[WAKE_BIT];
    end
  end

  // pin synchronisers
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], SCL_I};
      sda_sync <= {sda_sync[0], SDA_I};
    end
  end

  // clock glitch filter: follow only after a stable run
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scl_filt <= 1'b1;
      deb_cnt <= 3'h0;
    end else if (DEBOUNCE_CYCLES == DEBOUNCE_OFF || scl_sync[1] == scl_filt) begin
      scl_filt <= scl_sync[1]; // [RULE_06]
      deb_cnt <= 3'h0;
    end else if (deb_cnt == DEBOUNCE_CYCLES - 3'h1) begin
      scl_filt <= scl_sync[1]; // [RULE_25]
      deb_cnt <= 3'h0;
    end else begin
      deb_cnt <= deb_cnt + 3'h1;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_filt;
      sda_prev <= sda_sync[1];
    end
  end

  assign scl_rise = scl_filt & ~scl_prev;
  assign scl_fall = ~scl_filt & scl_prev;
  assign start_det = twowire_active && scl_filt && scl_prev && sda_prev && !sda_sync[1];
  assign stop_det = twowire_active && scl_filt && scl_prev && !sda_prev && sda_sync[1];

  // transfer engine, held idle unless enabled in two-wire slave mode
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      sda_low <= 1'b0;
    end else if (!twowire_active || stop_det) begin
      state <= ST_IDLE; // [RULE_26] [RULE_12]
      bit_cnt <= 4'h0;
      sda_low <= 1'b0;
    end else if (start_det) begin
      state <= ST_ADDR; // [RULE_02]
      // all ones: the start's own clock fall wraps it to the first bit
      bit_cnt <= '1;
      sda_low <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          sda_low <= 1'b0;
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise && bit_cnt <= BIT_LAST) begin
            shift <= {shift[6:0], sda_sync[1]};
          end
          if (scl_fall) begin
            if (bit_cnt == BIT_LAST) begin
              // ninth clock: ack for a matching address, the ack bit for data
              if (state == ST_ADDR) begin
                sda_low <= shift[7:1] == slave_address[7:1];
              end else begin
                sda_low <= ~ack_to_send; // [RULE_24]
              end
              bit_cnt <= ACK_SLOT;
            end else if (bit_cnt == ACK_SLOT) begin
              sda_low <= 1'b0;
              bit_cnt <= 4'h0;
              if (state == ST_ADDR && !address_match_flag) begin
                state <= ST_WAIT;
              end else if (state == ST_ADDR && read_write_flag) begin
                state <= ST_TX; // [RULE_03]
                sda_low <= ~shared_data[7]; // [RULE_19] [RULE_18]
                shift <= shared_data;
              end else begin
                state <= ST_RX;
              end
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        ST_TX: begin
          if (scl_rise && bit_cnt == ACK_SLOT && sda_sync[1]) begin
            state <= ST_WAIT; // master nack: release the line for its stop
          end
          if (scl_fall) begin
            if (bit_cnt == BIT_LAST) begin
              sda_low <= 1'b0;
              bit_cnt <= ACK_SLOT;
            end else if (bit_cnt == ACK_SLOT) begin
              // next byte: software reloads the shared data in between
              bit_cnt <= 4'h0;
              shift <= shared_data;
              sda_low <= ~shared_data[7];
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
              sda_low <= ~shift[6 - bit_cnt[2:0]];
            end
          end
        end
        ST_WAIT: begin
          sda_low <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
          sda_low <= 1'b0;
        end
      endcase
    end
  end

  // flags; enable rising returns them to reset values
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      transfer_complete_flag <= STATUS_RESET[TC_BIT];
      address_match_flag <= STATUS_RESET[AM_BIT];
      bus_busy_flag <= STATUS_RESET[BB_BIT];
      read_write_flag <= STATUS_RESET[RW_BIT];
      received_ack_flag <= STATUS_RESET[RXACK_BIT];
    end else if (enable_rise) begin
      transfer_complete_flag <= STATUS_RESET[TC_BIT]; // [RULE_16]
      address_match_flag <= STATUS_RESET[AM_BIT];
      bus_busy_flag <= STATUS_RESET[BB_BIT];
      read_write_flag <= STATUS_RESET[RW_BIT];
      received_ack_flag <= STATUS_RESET[RXACK_BIT];
    end else if (twowire_active) begin
      if (start_det) begin
        bus_busy_flag <= 1'b1; // [RULE_23]
      end else if (stop_det) begin
        bus_busy_flag <= 1'b0;
      end
      if (scl_fall && bit_cnt == 4'h0 && state != ST_IDLE && state != ST_WAIT) begin
        transfer_complete_flag <= 1'b0; // [RULE_21]
      end
      if (scl_fall && bit_cnt == BIT_LAST && state != ST_WAIT && state != ST_IDLE) begin
        transfer_complete_flag <= 1'b1;
        if (state == ST_ADDR) begin
          address_match_flag <= shift[7:1] == slave_address[7:1]; // [RULE_22]
          read_write_flag <= shift[0];
        end else begin
          address_match_flag <= 1'b0;
        end
      end
      if (state == ST_TX && scl_rise && bit_cnt == ACK_SLOT) begin
        received_ack_flag <= sda_sync[1];
      end
    end
  end

  // received byte lands in the shared register; it wins over a software write in the same cycle
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      shared_data <= SHARED_DATA_RESET;
    end else if (twowire_active && state == ST_RX && scl_fall && bit_cnt == BIT_LAST) begin
      shared_data <= shift; // [RULE_18] [RULE_20]
    end else if (byte_wr && ADR_I == ADDR_SHARED_DATA) begin
      shared_data <= DAT_I[7:0];
    end
  end

  assign IRQ_PULSE_O = twowire_active && scl_fall && bit_cnt == BIT_LAST
    && (state == ST_RX || state == ST_TX || (state == ST_ADDR && shift[7:1] == slave_address[7:1])); // [RULE_21]

  // open drain: output level is always low, enable pulls; clock never stretched
  assign SDA_O = 1'b0; // [RULE_01]
  assign SDA_OE_O = twowire_active & sda_low; // [RULE_12]
  assign SCL_O = 1'b0;
  assign SCL_OE_O = 1'b0; // [RULE_04]

  // shared prescaler for SPI master rate and clock output
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      presc <= '0;
      tm0_half <= 1'b0;
      clkout_div <= 1'b0;
    end else if (module_enable || mode_enable_control[CLKOUT_EN_BIT]) begin
      presc <= presc + 6'h01;
      if (TM0_MATCH_I) begin
        tm0_half <= ~tm0_half;
      end
      case (mode_enable_control[CLKOUT_SEL_MSB:CLKOUT_SEL_LSB]) // [RULE_11]
        CLKOUT_DIV4: clkout_div <= presc[1];
        CLKOUT_DIV8: clkout_div <= presc[2];
        CLKOUT_TM0: clkout_div <= tm0_half;
        default: clkout_div <= 1'b0;
      endcase
    end
  end

  // system-rate choice passes the clock itself, so it is gated combinationally
  assign CLOCK_OUT_PIN_O = mode_enable_control[CLKOUT_EN_BIT] &&
    (mode_enable_control[CLKOUT_SEL_MSB:CLKOUT_SEL_LSB] == CLKOUT_SYS ? MCLK_I : clkout_div); // [RULE_10]

  always_comb begin
    case (mode_field)
      MODE_SPI_DIV16: spi_last = PRESC_DIV16_LAST;
      MODE_SPI_DIV64: spi_last = PRESC_DIV64_LAST;
      default: spi_last = PRESC_DIV4_LAST;
    endcase
  end

  // SPI master rate tick for the SPI shifter outside this block
  assign SPI_SHIFT_TICK_O = module_enable && (
    (mode_field <= MODE_SPI_DIV64 && (presc & spi_last) == spi_last) ||
    (mode_field == MODE_SPI_TBC && TBC_TICK_I) ||
    (mode_field == MODE_SPI_TM0 && TM0_MATCH_I && tm0_half)); // [RULE_08]
  assign SPI_EXT_CLOCK_O = module_enable && mode_field == MODE_SPI_SLAVE; // [RULE_09]
endmodule

// [logic/smi2c_pkg.sv]
// package: register map, fields, reset values and codes for the serial module two-wire slave
package smi2c_pkg;
  // register byte addresses (wishbone, one aligned word each)
  localparam logic [3:0] ADDR_MODE_ENABLE_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_TWOWIRE_STATUS_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_SHARED_DATA = 4'h8;
  localparam logic [3:0] ADDR_SLAVE_ADDRESS = 4'hC;
  // mode_enable_control fields
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 5;
  localparam int CLKOUT_EN_BIT = 4;
  localparam int CLKOUT_SEL_MSB = 3;
  localparam int CLKOUT_SEL_LSB = 2;
  localparam int MODULE_EN_BIT = 1;
  localparam logic [7:0] MODE_ENABLE_RESET = 8'hE0;
  // twowire_status_control fields
  localparam int TC_BIT = 7;
  localparam int AM_BIT = 6;
  localparam int BB_BIT = 5;
  localparam int DIR_BIT = 4;
  localparam int ACK_BIT = 3;
  localparam int RW_BIT = 2;
  localparam int WAKE_BIT = 1;
  localparam int RXACK_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h81;
  localparam logic [7:0] SHARED_DATA_RESET = 8'h00;
  localparam logic [7:0] SLAVE_ADDRESS_RESET = 8'h00;
  // mode codes
  localparam logic [2:0] MODE_SPI_DIV4 = 3'h0;
  localparam logic [2:0] MODE_SPI_DIV16 = 3'h1;
  localparam logic [2:0] MODE_SPI_DIV64 = 3'h2;
  localparam logic [2:0] MODE_SPI_TBC = 3'h3;
  localparam logic [2:0] MODE_SPI_TM0 = 3'h4;
  localparam logic [2:0] MODE_SPI_SLAVE = 3'h5;
  localparam logic [2:0] MODE_TWOWIRE_SLAVE = 3'h6;
  localparam logic [2:0] MODE_UNUSED = 3'h7;
  // clock output select codes
  localparam logic [1:0] CLKOUT_SYS = 2'h0;
  localparam logic [1:0] CLKOUT_DIV4 = 2'h1;
  localparam logic [1:0] CLKOUT_DIV8 = 2'h2;
  localparam logic [1:0] CLKOUT_TM0 = 2'h3;
  // prescaler and filter sizes
  localparam int PRESC_W = 6;
  localparam logic [5:0] PRESC_DIV4_LAST = 6'h03;
  localparam logic [5:0] PRESC_DIV8_LAST = 6'h07;
  localparam logic [5:0] PRESC_DIV16_LAST = 6'h0F;
  localparam logic [5:0] PRESC_DIV64_LAST = 6'h3F;
  localparam logic [2:0] DEBOUNCE_OFF = 3'h0;
  localparam logic [2:0] DEBOUNCE_TWO = 3'h2;
  localparam logic [2:0] DEBOUNCE_FOUR = 3'h4;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // slave transfer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_RX = 5'b00100,
    ST_TX = 5'b01000,
    ST_WAIT = 5'b10000
  } smi2c_state_e;
endpackage

// [test/smi2c_slave_asserts.sv]
// checker: port-level assertions for the two-wire slave
`timescale 1ns/1ps
module smi2c_slave_asserts
  import smi2c_pkg::*;
(
  // clock, reset and register bus
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  // pins and status
  input wire logic SCL_I,
  input wire logic SCL_O,
  input wire logic SCL_OE_O,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic CLOCK_OUT_PIN_O,
  input wire logic IRQ_PULSE_O,
  input wire logic SPI_EXT_CLOCK_O
);
  logic [7:0] ctl;
  logic live;
  // shadow of the control register, taken on the request edge like the design
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctl <= MODE_ENABLE_RESET;
    end else if (CYC_I && STB_I && !ACK_O && WE_I && SEL_I[0] && ADR_I == ADDR_MODE_ENABLE_CONTROL) begin
      ctl <= DAT_I[7:0];
    end
  end
  assign live = ctl[MODULE_EN_BIT] && ctl[MODE_MSB:MODE_LSB] == MODE_TWOWIRE_SLAVE;
  default clocking dc @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  pins_low_only_a: assert property (SDA_O == 1'b0 && SCL_O == 1'b0 && SCL_OE_O == 1'b0)
    else $error("bus pin driven high or clock pulled");
  idle_release_a: assert property (!live |-> !SDA_OE_O)
    else $error("data line pulled while inactive");
  ack_low_phase_a: assert property ($changed(SDA_OE_O) |-> !SCL_I)
    else $error("data pull changed while clock high");
  irq_live_pulse_a: assert property (IRQ_PULSE_O |-> live ##1 !IRQ_PULSE_O)
    else $error("interrupt pulse wrong");
  ext_clock_mode_a: assert property (SPI_EXT_CLOCK_O |-> ctl[MODE_MSB:MODE_LSB] == MODE_SPI_SLAVE)
    else $error("external shift clock outside slave mode");
  clkout_gate_a: assert property (!ctl[CLKOUT_EN_BIT] |-> !CLOCK_OUT_PIN_O)
    else $error("clock output while disabled");
  ctl_read_a: assert property (ACK_O && !WE_I && ADR_I == ADDR_MODE_ENABLE_CONTROL
    |-> DAT_O == {24'h000000, ctl[7:1], 1'b0})
    else $error("control read value wrong");
  wb_ack_pulse_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
    else $error("bus acknowledge timing wrong");
endmodule

bind smi2c_slave smi2c_slave_asserts u_asserts (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .SCL_I(SCL_I), .SCL_O(SCL_O), .SCL_OE_O(SCL_OE_O), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .CLOCK_OUT_PIN_O(CLOCK_OUT_PIN_O), .IRQ_PULSE_O(IRQ_PULSE_O), .SPI_EXT_CLOCK_O(SPI_EXT_CLOCK_O));

// [test/smi2c_master_model.sv]
// partner: two-wire bus master making start, stop and the clock
`timescale 1ns/1ps
module smi2c_master_model (
  // clock and sensed data line
  input wire logic clk_i,
  input wire logic sda_i,
  // open-drain pulls, high pulls the line low
  output logic scl_low_o,
  output logic sda_low_o
);
  // half phase kept above the slave's minimum of 8 cycles
  localparam int HALF = 10;
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  task automatic wait_half();
    repeat (HALF) @(posedge clk_i);
  endtask
  // data falls while clock released
  task automatic start();
    sda_low_o <= 1'b0;
    wait_half();
    scl_low_o <= 1'b0;
    wait_half();
    sda_low_o <= 1'b1;
    wait_half();
    scl_low_o <= 1'b1;
    wait_half();
  endtask
  // data rises while clock released
  task automatic stop();
    sda_low_o <= 1'b1;
    wait_half();
    scl_low_o <= 1'b0;
    wait_half();
    sda_low_o <= 1'b0;
    wait_half();
  endtask
  // data set in low phase, sampled at end of high phase
  task automatic clk_bit(input logic b, output logic r);
    sda_low_o <= !b;
    wait_half();
    scl_low_o <= 1'b0;
    wait_half();
    r = sda_i;
    scl_low_o <= 1'b1;
    wait_half();
  endtask
  // eight bits msb first, then the acknowledge clock
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
    clk_bit(ack_in, ack_out);
  endtask
endmodule

// [test/smi2c_slave_tb.sv]
// testbench: registers, clock sources and two-wire traffic for the slave
`timescale 1ns/1ps
module smi2c_slave_tb;
  import smi2c_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, tbc = 1'b0, tm0 = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, scl_o, scl_oe, sda_o, sda_oe, ck_out, irq, tick, ext, m_scl, m_sda;
  logic [7:0] cnt = 8'h00;
  int n_errors = 0, checks_done = 0, irqs = 0;
  // released lines float to the pull-up level
  wire scl_w = !(m_scl || (scl_oe && !scl_o));
  wire sda_w = !(m_sda || (sda_oe && !sda_o));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cnt <= cnt + 8'h01;
    tm0 <= (cnt[1:0] == 2'h0);
    tbc <= 1'($urandom);
    if (irq === 1'b1) irqs <= irqs + 1;
  end
  smi2c_slave #(.PIN_OPTION(1'b1), .DEBOUNCE_CYCLES(DEBOUNCE_TWO)) dut (.MCLK_I(clk), .RST_N_I(rst_n),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
    .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .TBC_TICK_I(tbc), .TM0_MATCH_I(tm0), .CLOCK_OUT_PIN_O(ck_out), .IRQ_PULSE_O(irq),
    .SPI_SHIFT_TICK_O(tick), .SPI_EXT_CLOCK_O(ext));
  smi2c_master_model bm (.clk_i(clk), .sda_i(sda_w), .scl_low_o(m_scl), .sda_low_o(m_sda));
  task automatic close_out();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic s, output logic [7:0] r);
    int n;
    n = 0;
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    sel <= {3'b111, s};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      n_errors++;
      close_out();
    end
    r = rdat[7:0];
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, 1'b1, r);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, 1'b1, r);
    chk(r, e);
  endtask
  // rising edges of the tick or the clock output over 64 cycles
  task automatic count(input logic pin, output int c);
    logic p, v;
    c = 0;
    @(posedge clk);
    #1 p = pin ? ck_out : tick;
    repeat (64) begin
      @(posedge clk);
      #1 v = pin ? ck_out : tick;
      if (v === 1'b1 && p !== 1'b1) c++;
      p = v;
    end
    @(posedge clk);
  endtask
  // timer match comes every 4 cycles, so its half rate gives 8
  function automatic int exp_ticks(input logic [2:0] m);
    case (m)
      MODE_SPI_DIV4: return 16;
      MODE_SPI_DIV16: return 4;
      MODE_SPI_DIV64: return 1;
      default: return 8;
    endcase
  endfunction
  initial begin
    logic [7:0] r, d, t;
    logic [6:0] a7;
    logic k;
    int c;
    void'($urandom(21902));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(ADDR_MODE_ENABLE_CONTROL, MODE_ENABLE_RESET);
    rdchk(ADDR_TWOWIRE_STATUS_CONTROL, STATUS_RESET);
    rdchk(ADDR_SHARED_DATA, SHARED_DATA_RESET);
    rdchk(4'h2, 8'h00);
    bus(1'b1, ADDR_SLAVE_ADDRESS, 8'h5A, 1'b0, r);
    rdchk(ADDR_SLAVE_ADDRESS, SLAVE_ADDRESS_RESET);
    for (int m = 0; m < 8; m++) begin
      d = {m[2:0], 3'($urandom), 1'b1, 1'($urandom)};
      wr(ADDR_MODE_ENABLE_CONTROL, d);
      rdchk(ADDR_MODE_ENABLE_CONTROL, d & 8'hFE);
      chk(ext, m == 5);
      if (m == 3) #1 chk(tick, tbc);
      count(1'b0, c);
      if (m inside {0, 1, 2, 4}) chk(c, exp_ticks(m[2:0]));
    end
    for (int s = 1; s < 4; s++) begin
      wr(ADDR_MODE_ENABLE_CONTROL, {MODE_UNUSED, 1'b1, s[1:0], 2'b00});
      count(1'b1, c);
      chk(c, s == 1 ? 16 : 8);
    end
    wr(ADDR_MODE_ENABLE_CONTROL, {MODE_UNUSED, 1'b1, CLKOUT_SYS, 2'b00});
    @(posedge clk);
    #1 chk(ck_out, 1'b1);
    @(posedge clk);
    a7 = 7'($urandom);
    wr(ADDR_SLAVE_ADDRESS, {a7, 1'b0});
    wr(ADDR_MODE_ENABLE_CONTROL, 8'hC0);
    bm.start();
    bm.xfer({a7, 1'b0}, 1'b1, r, k);
    chk(k, 1'b1);
    bm.stop();
    wr(ADDR_MODE_ENABLE_CONTROL, 8'hC2);
    bm.start();
    rdchk(ADDR_TWOWIRE_STATUS_CONTROL, 8'hA1);
    bm.xfer({a7, 1'b0}, 1'b1, r, k);
    chk(k, 1'b0);
    rdchk(ADDR_TWOWIRE_STATUS_CONTROL, 8'hE1);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      wr(ADDR_TWOWIRE_STATUS_CONTROL, {4'h0, i[0], 3'h0});
      bm.xfer(d, 1'b1, r, k);
      chk(k, i[0]);
      rdchk(ADDR_SHARED_DATA, d);
    end
    bm.stop();
    bus(1'b0, ADDR_TWOWIRE_STATUS_CONTROL, 8'h00, 1'b1, r);
    chk(r[BB_BIT], 1'b0);
    t = 8'($urandom);
    wr(ADDR_SHARED_DATA, t);
    wr(ADDR_TWOWIRE_STATUS_CONTROL, 8'h10);
    bm.start();
    bm.xfer({a7, 1'b1}, 1'b1, r, k);
    chk(k, 1'b0);
    bus(1'b0, ADDR_TWOWIRE_STATUS_CONTROL, 8'h00, 1'b1, r);
    chk(r[RW_BIT], 1'b1);
    bm.xfer(8'hFF, 1'b1, r, k);
    chk(r, t);
    bm.stop();
    wr(ADDR_TWOWIRE_STATUS_CONTROL, 8'h00);
    bm.start();
    bm.xfer({a7 ^ 7'h01, 1'b0}, 1'b1, r, k);
    chk(k, 1'b1);
    bus(1'b0, ADDR_TWOWIRE_STATUS_CONTROL, 8'h00, 1'b1, r);
    chk(r[AM_BIT], 1'b0);
    bm.stop();
    wr(ADDR_MODE_ENABLE_CONTROL, 8'hA2);
    bm.start();
    bm.xfer({a7, 1'b0}, 1'b1, r, k);
    chk(k, 1'b1);
    bm.stop();
    wr(ADDR_MODE_ENABLE_CONTROL, 8'hC2);
    bm.start();
    bm.xfer({a7, 1'b0}, 1'b1, r, k);
    wr(ADDR_MODE_ENABLE_CONTROL, 8'hC0);
    wr(ADDR_TWOWIRE_STATUS_CONTROL, 8'h18);
    wr(ADDR_MODE_ENABLE_CONTROL, 8'hC2);
    rdchk(ADDR_TWOWIRE_STATUS_CONTROL, 8'h99);
    bm.stop();
    chk(irqs, 6);
    close_out();
  end
endmodule
